// file: hw/link_sampler.sv
`timescale 1ns/100ps
// two-flop synchroniser for link pins plus edge finder on the clock line
module link_sampler (
   // system side
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   // link pins
   input  wire logic sclk_i,
   input  wire logic data_i,
   // sampled results
   output logic      data_o,
   output logic      rise_o,
   output logic      fall_o
);

   logic [1:0] sclk_sync_reg;
   logic [1:0] data_sync_reg;
   logic       sclk_prev_reg;

   // first stage feeds only the second stage, edge logic looks at stage two
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sclk_sync_reg <= 2'h0;
         data_sync_reg <= 2'h0;
         sclk_prev_reg <= 1'b0;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[0], sclk_i};
         data_sync_reg <= {data_sync_reg[0], data_i};
         sclk_prev_reg <= sclk_sync_reg[1];
      end
   end

   // edges are one system cycle wide
   assign data_o = data_sync_reg[1];
   assign rise_o = sclk_sync_reg[1] & ~sclk_prev_reg;
   assign fall_o = ~sclk_sync_reg[1] & sclk_prev_reg;

endmodule

// file: hw/spi_flag_pkg.sv
package spi_flag_pkg;

   // transfer engine states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN  = 2'b01
   } xfer_state_t;

   // whole state of the flag block
   typedef struct packed {
      xfer_state_t st;
      logic [2:0]  bit_cnt;
      logic [7:0]  shift;
      logic        samp;
      logic [7:0]  rx_buf;
      logic [7:0]  tx_buf;
      logic        tx_full;
      logic        rx_interrupt_flag;
      logic        rx_buffer_full_flag;
      logic        tx_underflow_flag;
      logic        tx_interrupt_flag;
      logic        rx_overflow_flag;
      logic        transfer_initiate_mode;
      logic        rx_overwrite_enable;
      logic        stop_req;
      logic [3:0]  evt;
      logic [3:0]  mask;
      logic [7:0]  rdata;
      logic        irq;
      logic        ss_n;
      logic        mosi;
   } flag_state_t;

endpackage

// file: hw/spi_flag_regs.svh
`ifndef SPI_FLAG_REGS_SVH
`define SPI_FLAG_REGS_SVH

// register offsets on the plain register port
`define OFS_STATUS     4'h0
`define OFS_RXBUF      4'h1
`define OFS_CTRL       4'h2
`define OFS_TXBUF      4'h3
`define OFS_INT_STAT   4'h4
`define OFS_INT_MASK   4'h5

// status register bit positions
`define ST_BUSY_BIT    0
`define ST_TXIRQ_BIT   1
`define ST_TXUF_BIT    2
`define ST_RXBF_BIT    3
`define ST_RXIRQ_BIT   4
`define ST_RXOF_BIT    5

// control register bit positions
`define CT_MODE_BIT    0
`define CT_OVW_BIT     1
`define CT_START_BIT   2
`define CT_STOP_BIT    3

// interrupt status and mask bit positions
`define EV_TXUF_BIT    0
`define EV_RXOF_BIT    1
`define EV_TX_BIT      2
`define EV_RX_BIT      3

// reset values and the idle fill byte
`define RST_FLAGS      1'b0
`define RST_BYTE       8'h00
`define RST_EVT        4'h0
`define IDLE_FILL      8'hFF

// bits per byte transfer, counter wraps to zero after the last one
`define BIT_CNT_LAST   3'h7

`endif

// file: hw/spi_status_flag_logic.sv
// Functional notes
// - rx flag raises interrupt in receive-initiated mode
// - unread rx buffer at byte end halts receive-initiated mode, releases select
// - transmit-initiated mode: rx flag only signals data
// - rx full bit set, cleared by buffer read
// - tx underflow bit set, software writes zero
// - writing transmit buffer clears tx flag
// - tx flag clear while occupied, set empty; reset leaves it clear with the buffer empty, it is set only once a byte leaves
// - unread byte overflows; overwrite option replaces buffer
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`include "spi_flag_regs.svh"

module spi_status_flag_logic
   import spi_flag_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   // register port
   input  wire logic [3:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   // serial link
   input  wire logic       sclk_i,
   input  wire logic       miso_i,
   output logic            mosi_o,
   output logic            ss_n_o,
   // interrupt
   output logic            irq_o
);

   ////////////////////////////////////////////////////////////////////////
   // link pin sampling

   logic miso_s;
   logic sclk_rise;
   logic sclk_fall;

   // clock and data pass the same two stages, so they keep their order;
   // an edge is seen about three system cycles late, so each link clock
   // phase must last at least three system cycles
   link_sampler u_link (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .sclk_i    (sclk_i),
      .data_i    (miso_i),
      .data_o    (miso_s),
      .rise_o    (sclk_rise),
      .fall_o    (sclk_fall)
   );

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // status register image, shared by read decode
   function automatic logic [7:0] status_image(input flag_state_t s);
      logic [7:0] v;
      v = 8'h00;
      // busy comes from the engine state, it is not stored on its own
      v[`ST_BUSY_BIT]  = (s.st == ST_RUN);
      v[`ST_TXIRQ_BIT] = s.tx_interrupt_flag;
      v[`ST_TXUF_BIT]  = s.tx_underflow_flag;
      v[`ST_RXBF_BIT]  = s.rx_buffer_full_flag;
      v[`ST_RXIRQ_BIT] = s.rx_interrupt_flag;
      v[`ST_RXOF_BIT]  = s.rx_overflow_flag;
      return v;
   endfunction

   // control register image
   function automatic logic [7:0] ctrl_image(input flag_state_t s);
      logic [7:0] v;
      v = 8'h00;
      // start is a command and always reads back as zero
      v[`CT_MODE_BIT] = s.transfer_initiate_mode;
      v[`CT_OVW_BIT]  = s.rx_overwrite_enable;
      v[`CT_STOP_BIT] = s.stop_req;
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // state

   // one struct holds every register of the block outside the link sampler
   flag_state_t cur_reg;
   flag_state_t cur_next;

   // decoded strobes and engine helpers
   logic       wr_status;
   logic       wr_ctrl;
   logic       wr_txbuf;
   logic       wr_int_stat;
   logic       wr_int_mask;
   logic       rd_rxbuf;
   logic [7:0] rx_byte;
   logic       byte_end;
   logic [3:0] evt_set;

   ////////////////////////////////////////////////////////////////////////
   // register port

   // register port decode; each strobe is live for one edge only
   assign wr_status   = wr_i && (addr_i == `OFS_STATUS);
   assign wr_ctrl     = wr_i && (addr_i == `OFS_CTRL);
   assign wr_txbuf    = wr_i && (addr_i == `OFS_TXBUF);
   assign wr_int_stat = wr_i && (addr_i == `OFS_INT_STAT);
   assign wr_int_mask = wr_i && (addr_i == `OFS_INT_MASK);
   assign rd_rxbuf    = rd_i && (addr_i == `OFS_RXBUF);

   ////////////////////////////////////////////////////////////////////////
   // byte timing

   // byte completes on the falling link edge after the eighth rise;
   // the count also reads zero before the first rise, so the link clock
   // must rest low when a byte starts or its first fall ends the byte
   assign rx_byte  = {cur_reg.shift[6:0], cur_reg.samp};
   assign byte_end = (cur_reg.st == ST_RUN) && sclk_fall &&
                     (cur_reg.bit_cnt == 3'h0);

   ////////////////////////////////////////////////////////////////////////
   // next-state logic
   // order matters: software clears first, engine sets after, so a flag
   // set in the same cycle as its clear survives, except the tx flag: the
   // transmit buffer write comes last so fresh data is never swallowed by
   // a load, and its clear of the tx flag wins over a set

   always_comb begin
      cur_next = cur_reg;
      evt_set  = 4'h0;

      // read data stands only in the cycle after the read strobe
      cur_next.rdata = 8'h00;
      if (rd_i) begin
         unique case (addr_i)
            `OFS_STATUS:   cur_next.rdata = status_image(cur_reg);
            `OFS_RXBUF:    cur_next.rdata = cur_reg.rx_buf;
            `OFS_CTRL:     cur_next.rdata = ctrl_image(cur_reg);
            `OFS_INT_STAT: cur_next.rdata = {4'h0, cur_reg.evt};
            `OFS_INT_MASK: cur_next.rdata = {4'h0, cur_reg.mask};
            default:       cur_next.rdata = 8'h00;
         endcase
      end

      // reading the receive buffer clears both receive flags; a read in
      // the cycle of a byte end counts as servicing the old byte, and the
      // engine below sets the flags again for the new one
      if (rd_rxbuf) begin
         cur_next.rx_interrupt_flag   = 1'b0;
         cur_next.rx_buffer_full_flag = 1'b0;
      end

      // writing zero clears underflow or overflow; ones are ignored,
      // so writing back a status word just read cannot clear a bit
      if (wr_status) begin
         if (!wdata_i[`ST_TXUF_BIT])
            cur_next.tx_underflow_flag = 1'b0;
         if (!wdata_i[`ST_RXOF_BIT])
            cur_next.rx_overflow_flag = 1'b0;
      end

      // mode bits, start is a self-clearing command
      if (wr_ctrl) begin
         cur_next.transfer_initiate_mode = wdata_i[`CT_MODE_BIT];
         cur_next.rx_overwrite_enable    = wdata_i[`CT_OVW_BIT];
         cur_next.stop_req               = wdata_i[`CT_STOP_BIT];
      end

      // interrupt bookkeeping registers; a written one clears an event,
      // but an event arriving in the same cycle wins in the merge below
      if (wr_int_stat)
         cur_next.evt = cur_reg.evt & ~wdata_i[3:0];
      if (wr_int_mask)
         cur_next.mask = wdata_i[3:0];

      // transfer engine; it reads the mode from the register, not from a
      // write in flight, so a mode change and a start need two writes
      unique case (cur_reg.st)
         ST_IDLE: begin
            // data out rests high between frames
            cur_next.ss_n = 1'b1;
            cur_next.mosi = 1'b1;
            if (cur_reg.transfer_initiate_mode && cur_reg.tx_full) begin
               // transmit-initiated: a full buffer starts the byte
               cur_next.shift             = cur_reg.tx_buf;
               cur_next.mosi              = cur_reg.tx_buf[7];
               cur_next.tx_full           = 1'b0;
               cur_next.tx_interrupt_flag = 1'b1;
               cur_next.bit_cnt           = 3'h0;
               cur_next.ss_n              = 1'b0;
               cur_next.st                = ST_RUN;
            end else if (!cur_reg.transfer_initiate_mode && wr_ctrl &&
                         wdata_i[`CT_START_BIT]) begin
               // receive-initiated: software start, idle fill if empty
               cur_next.shift    = cur_reg.tx_full ? cur_reg.tx_buf
                                                   : `IDLE_FILL;
               cur_next.mosi     = cur_reg.tx_full ? cur_reg.tx_buf[7]
                                                   : 1'b1;
               // a queued byte leaves the buffer, so the flag shows empty
               if (cur_reg.tx_full)
                  cur_next.tx_interrupt_flag = 1'b1;
               cur_next.tx_full  = 1'b0;
               cur_next.stop_req = 1'b0;
               cur_next.bit_cnt  = 3'h0;
               cur_next.ss_n     = 1'b0;
               cur_next.st       = ST_RUN;
            end
         end
         ST_RUN: begin
            // sample on the rising link edge, shift on the falling one;
            // the half period between them lets data out settle first
            if (sclk_rise) begin
               cur_next.samp    = miso_s;
               cur_next.bit_cnt = cur_reg.bit_cnt + 3'h1;
            end
            if (sclk_fall && !byte_end) begin
               cur_next.shift = rx_byte;
               cur_next.mosi  = cur_reg.shift[6];
            end
            if (byte_end) begin
               cur_next.shift = rx_byte;
               if (cur_reg.rx_interrupt_flag && !rd_rxbuf) begin
                  // previous byte still unread
                  cur_next.rx_overflow_flag = 1'b1;
                  if (cur_reg.rx_overwrite_enable)
                     cur_next.rx_buf = rx_byte;
               end else begin
                  cur_next.rx_buf              = rx_byte;
                  cur_next.rx_interrupt_flag   = 1'b1;
                  cur_next.rx_buffer_full_flag = 1'b1;
               end

               if (!cur_reg.transfer_initiate_mode &&
                   cur_reg.rx_interrupt_flag && !rd_rxbuf) begin
                  // software fell behind: stop and release select; the
                  // overflow is already flagged above, the old byte stays
                  // unless the overwrite option replaced it
                  cur_next.ss_n = 1'b1;
                  cur_next.st   = ST_IDLE;
               end else if (cur_reg.transfer_initiate_mode) begin
                  // transmit-initiated keeps going while data is queued;
                  // a reload sets the tx flag again, the buffer just emptied
                  if (cur_reg.tx_full) begin
                     cur_next.shift             = cur_reg.tx_buf;
                     cur_next.mosi              = cur_reg.tx_buf[7];
                     cur_next.tx_full           = 1'b0;
                     cur_next.tx_interrupt_flag = 1'b1;
                  end else begin
                     // nothing queued: flag underflow and close the frame
                     cur_next.tx_underflow_flag = 1'b1;
                     cur_next.ss_n              = 1'b1;
                     cur_next.st                = ST_IDLE;
                  end
               end else if (cur_reg.stop_req ||
                            (wr_ctrl && wdata_i[`CT_STOP_BIT])) begin
                  // receive-initiated with the buffer serviced ends only on request
                  cur_next.stop_req = 1'b0;
                  cur_next.ss_n     = 1'b1;
                  cur_next.st       = ST_IDLE;
               end else begin
                  cur_next.shift   = cur_reg.tx_full ? cur_reg.tx_buf
                                                     : `IDLE_FILL;
                  cur_next.mosi    = cur_reg.tx_full ? cur_reg.tx_buf[7]
                                                     : 1'b1;
                  if (cur_reg.tx_full)
                     cur_next.tx_interrupt_flag = 1'b1;
                  cur_next.tx_full = 1'b0;
               end
            end
         end
      endcase

      // a write refills the buffer and marks it occupied again; there is
      // no guard, a write while full replaces the queued byte
      if (wr_txbuf) begin
         cur_next.tx_buf            = wdata_i;
         cur_next.tx_full           = 1'b1;
         cur_next.tx_interrupt_flag = 1'b0;
      end

      // events are taken on flag edges, so a flag that stays set
      // raises its event only once
      // sticky events on rising flags; the rx event only counts in
      // receive-initiated mode, tx only in transmit-initiated mode
      evt_set[`EV_RX_BIT] = cur_next.rx_interrupt_flag &
                            ~cur_reg.rx_interrupt_flag &
                            ~cur_reg.transfer_initiate_mode;
      evt_set[`EV_TX_BIT] = cur_next.tx_interrupt_flag &
                            ~cur_reg.tx_interrupt_flag &
                            cur_reg.transfer_initiate_mode;
      evt_set[`EV_RXOF_BIT] = cur_next.rx_overflow_flag &
                              ~cur_reg.rx_overflow_flag;
      evt_set[`EV_TXUF_BIT] = cur_next.tx_underflow_flag &
                              ~cur_reg.tx_underflow_flag;
      cur_next.evt = cur_next.evt | evt_set;

      // level interrupt, high while any unmasked event stands;
      // registered with the events, so it changes in the same cycle as they do
      cur_next.irq = |(cur_next.evt & cur_next.mask);
   end

   ////////////////////////////////////////////////////////////////////////
   // state register

   // synchronous reset; every field is named so none is left undefined
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cur_reg.st                     <= ST_IDLE;
         cur_reg.bit_cnt                <= 3'h0;
         cur_reg.shift                  <= `RST_BYTE;
         cur_reg.samp                   <= 1'b0;
         cur_reg.rx_buf                 <= `RST_BYTE;
         cur_reg.tx_buf                 <= `RST_BYTE;
         cur_reg.tx_full                <= 1'b0;
         cur_reg.rx_interrupt_flag      <= `RST_FLAGS;
         cur_reg.rx_buffer_full_flag    <= `RST_FLAGS;
         cur_reg.tx_underflow_flag      <= `RST_FLAGS;
         cur_reg.tx_interrupt_flag      <= `RST_FLAGS;
         cur_reg.rx_overflow_flag       <= `RST_FLAGS;
         cur_reg.transfer_initiate_mode <= 1'b0;
         cur_reg.rx_overwrite_enable    <= 1'b0;
         cur_reg.stop_req               <= 1'b0;
         cur_reg.evt                    <= `RST_EVT;
         cur_reg.mask                   <= `RST_EVT;
         cur_reg.rdata                  <= `RST_BYTE;
         cur_reg.irq                    <= 1'b0;
         cur_reg.ss_n                   <= 1'b1;
         cur_reg.mosi                   <= 1'b1;
      end else begin
         cur_reg <= cur_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   // outputs straight from the state register, no logic behind them,
   // so the pins never glitch
   assign rdata_o = cur_reg.rdata;
   assign irq_o   = cur_reg.irq;
   assign ss_n_o  = cur_reg.ss_n;
   assign mosi_o  = cur_reg.mosi;

endmodule

// file: verif/spi_far_master.sv
`timescale 1ns/100ps
// outside link master: clocks only while selected, 160 ns bit period
module spi_far_master #(
   parameter int GAP_NS = 247
) (
   // link pins
   input  wire logic        ss_n_i,
   input  wire logic        mosi_i,
   output logic             sclk_o,
   output logic             miso_o,
   // bench side
   input  wire logic [7:0]  pat_i,
   output logic      [31:0] got_o,
   output int               byte_cnt_o
);
   logic [7:0] tx;
   logic [7:0] rx;
   int         i;
   ////////////////////////////////////////////////////////////////////////
   // odd bytes send the inverted pattern so overwrite shows a new value;
   // the odd gap keeps link edges off the system clock edges
   initial begin
      sclk_o = 1'b0;
      miso_o = 1'b1;
      got_o = 32'h0;
      byte_cnt_o = 0;
      forever begin
         wait (ss_n_i == 1'b0);
         #GAP_NS;
         while (!ss_n_i) begin
            tx = pat_i ^ {8{byte_cnt_o[0]}};
            for (i = 7; i >= 0; i--) begin
               miso_o = tx[i]; // msb first
               #80 sclk_o = 1'b1;
               #60 rx[i] = mosi_i; // late sample: data out moves late
               #20 sclk_o = 1'b0;
            end
            got_o = {got_o[23:0], rx};
            byte_cnt_o++;
            #GAP_NS;
         end
         miso_o = ~miso_o; // released line shows no stale level
      end
   end
endmodule

// file: verif/spi_flag_sva.sv
`timescale 1ns/100ps
`include "spi_flag_regs.svh"
module spi_flag_sva (
   // clock and reset
   input wire logic       clk_i,
   input wire logic       sys_rst_i,
   // register port
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic       wr_i,
   input wire logic       rd_i,
   input wire logic [7:0] rdata_o,
   // link and interrupt
   input wire logic       sclk_i,
   input wire logic       miso_i,
   input wire logic       mosi_o,
   input wire logic       ss_n_o,
   input wire logic       irq_o
);
   default clocking dc @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   ////////////////////////////////////////////////////////////////////////
   // select idle for two samples: no byte end can be pending
   sequence s_quiet;
      ss_n_o && $past(ss_n_o);
   endsequence
   sequence s_rd_status;
      rd_i && addr_i == `OFS_STATUS;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   chk_reset_quiet: assert property (disable iff (1'b0)
      sys_rst_i |=> ss_n_o && !irq_o && rdata_o == 8'h00)
      else $error("outputs not quiet after reset");
   chk_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("read data outside read window");
   chk_rxbuf_clears: assert property (
      s_quiet ##0 (rd_i && addr_i == `OFS_RXBUF) ##[1:2] s_rd_status
      |=> !rdata_o[`ST_RXBF_BIT] && !rdata_o[`ST_RXIRQ_BIT])
      else $error("receive flags survive buffer read");
   // sclk high around the write keeps a byte end out of the window
   chk_txbuf_clears: assert property (
      (wr_i && addr_i == `OFS_TXBUF && !ss_n_o && sclk_i && $past(sclk_i))
      ##[1:2] s_rd_status |=> !rdata_o[`ST_TXIRQ_BIT])
      else $error("transmit flag set with buffer occupied");
   chk_status_zero: assert property (
      s_quiet ##0 (wr_i && addr_i == `OFS_STATUS && wdata_i == 8'h00)
      ##[1:2] s_rd_status
      |=> !rdata_o[`ST_TXUF_BIT] && !rdata_o[`ST_RXOF_BIT])
      else $error("write of zero left status bits set");
   chk_int_clear: assert property (
      s_quiet ##0 (wr_i && addr_i == `OFS_INT_STAT && wdata_i == 8'h0F)
      ##1 ss_n_o |=> !irq_o)
      else $error("interrupt stays after clearing all events");
   chk_mask_off: assert property (
      s_quiet ##0 (wr_i && addr_i == `OFS_INT_MASK && wdata_i == 8'h00)
      ##1 ss_n_o |=> !irq_o)
      else $error("interrupt stays with all events masked");
   chk_start_cause: assert property (
      $fell(ss_n_o) |-> $past(wr_i) || $past(wr_i, 2))
      else $error("select asserted without a start write");
   chk_mosi_idle: assert property (s_quiet |-> mosi_o)
      else $error("data out not idle while deselected");
endmodule

bind spi_status_flag_logic spi_flag_sva i_spi_flag_sva (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .sclk_i(sclk_i), .miso_i(miso_i), .mosi_o(mosi_o),
   .ss_n_o(ss_n_o), .irq_o(irq_o));

// file: verif/testbench.sv
`timescale 1ns/100ps
`include "spi_flag_regs.svh"
module testbench;
   logic        clk_i;
   logic        sys_rst_i;
   logic [3:0]  addr_i;
   logic [7:0]  wdata_i;
   logic        wr_i;
   logic        rd_i;
   logic [7:0]  rdata_o;
   logic        sclk_i;
   logic        miso_i;
   logic        mosi_o;
   logic        ss_n_o;
   logic        irq_o;
   logic [7:0]  pat;
   logic [7:0]  d;
   logic [31:0] got;
   int          nbytes;
   int          failures;
   int          check_count;
   ////////////////////////////////////////////////////////////////////////
   spi_status_flag_logic i_spi_status_flag_logic (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .sclk_i(sclk_i), .miso_i(miso_i), .mosi_o(mosi_o),
      .ss_n_o(ss_n_o), .irq_o(irq_o));
   spi_far_master i_spi_far_master (
      .ss_n_i(ss_n_o), .mosi_i(mosi_o), .sclk_o(sclk_i), .miso_o(miso_i),
      .pat_i(pat), .got_o(got), .byte_cnt_o(nbytes));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] s);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   // one-cycle strobes; a gap cycle between calls keeps drivers race free
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   // bounded wait: sel 0 waits for irq_o high, sel 1 for select released
   task automatic wait_for(input bit sel);
      int n;
      n = 0;
      while ((sel ? ss_n_o : irq_o) !== 1'b1 && n < 2000) begin
         @(posedge clk_i);
         #1 n++;
      end
      chk(sel ? "ss_n_o" : "irq_o", 8'h01, {7'h0, sel ? ss_n_o : irq_o});
   endtask
   task automatic results;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // whole run is under a thousand cycles; this cuts a hang short
   initial begin
      #200000;
      failures++;
      results;
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      sys_rst_i = 1'b1;
      addr_i = 4'h0;
      wdata_i = 8'h00;
      wr_i = 1'b0;
      rd_i = 1'b0;
      pat = 8'h3C;
      failures = 0;
      check_count = 0;
      repeat (4) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      #1 chk("ss_n_o", 8'h01, {7'h0, ss_n_o});
      chk("irq_o", 8'h00, {7'h0, irq_o});
      rd(`OFS_STATUS);
      chk("status", 8'h00, d);
      rd(`OFS_INT_STAT);
      chk("int_stat", 8'h00, d);
      rd(4'hF);
      chk("unmapped", 8'h00, d);
      // transmit-initiated: two bytes back to back, receive never read
      wr(`OFS_CTRL, 8'h01);
      wr(`OFS_INT_MASK, 8'h0F);
      wr(`OFS_TXBUF, 8'hA5);
      rd(`OFS_STATUS);
      chk("status empty", 8'h03, d);
      @(posedge sclk_i);
      wr(`OFS_TXBUF, 8'h5A);
      rd(`OFS_STATUS);
      chk("status full", 8'h01, d);
      wait_for(1'b1);
      chk("bytes", 8'h02, nbytes[7:0]);
      chk("mosi byte0", 8'hA5, got[15:8]);
      chk("mosi byte1", 8'h5A, got[7:0]);
      rd(`OFS_STATUS);
      chk("status end", 8'h3E, d);
      chk("irq_o", 8'h01, {7'h0, irq_o});
      rd(`OFS_INT_STAT);
      chk("int_stat", 8'h07, d);
      rd(`OFS_RXBUF);
      chk("rx kept", 8'h3C, d);
      rd(`OFS_STATUS);
      chk("status read", 8'h26, d);
      wr(`OFS_STATUS, 8'hFF);
      rd(`OFS_STATUS);
      chk("status ones", 8'h26, d);
      wr(`OFS_STATUS, 8'h00);
      rd(`OFS_STATUS);
      chk("status zero", 8'h02, d);
      wr(`OFS_INT_STAT, 8'h0F);
      repeat (2) @(posedge clk_i);
      #1 chk("irq_o", 8'h00, {7'h0, irq_o});
      // receive-initiated with overwrite: halts when left unread
      wr(`OFS_INT_MASK, 8'h00);
      wr(`OFS_INT_MASK, 8'h08);
      pat <= 8'h96;
      // the mode must settle before the start command is written
      wr(`OFS_CTRL, 8'h02);
      wr(`OFS_CTRL, 8'h06);
      wait_for(1'b0);
      wait_for(1'b1);
      chk("bytes", 8'h04, nbytes[7:0]);
      chk("mosi fill", 8'hFF, got[7:0]);
      rd(`OFS_STATUS);
      chk("status rx", 8'h38, d & 8'h38);
      rd(`OFS_INT_STAT);
      chk("int rx", 8'h08, d & 8'h08);
      rd(`OFS_RXBUF);
      chk("rx overwrite", 8'h69, d);
      // buffer serviced: one byte ends on a stop request, no halt
      wr(`OFS_CTRL, 8'h06);
      wr(`OFS_CTRL, 8'h0A);
      wait_for(1'b1);
      chk("bytes", 8'h05, nbytes[7:0]);
      rd(`OFS_STATUS);
      chk("status single", 8'h18, d & 8'h18);
      rd(`OFS_CTRL);
      chk("ctrl", 8'h02, d);
      rd(`OFS_RXBUF);
      chk("rx single", 8'h96, d);
      results;
   end
endmodule
